// ===== include/mcs_pkg.sv
// constants and types shared by the modem command block
package mcs_pkg;

    // register numbers as given in the command string
    localparam logic [7:0] REG_MODULATION_SELECT = 8'h07;
    localparam logic [7:0] REG_CALLER_ID_FORMAT = 8'h13;
    localparam logic [7:0] REG_ALERT_ENABLE = 8'he2;
    localparam logic [7:0] REG_TX_TEST_CONTROL = 8'he5;
    localparam logic [7:0] REG_TX_TEST_PATTERN = 8'he6;
    localparam logic [7:0] REG_DSP_MODE = 8'he8;
    localparam logic [7:0] REG_LINE_IF_COUNTRY = 8'hf5;
    localparam logic [7:0] REG_LINE_IF_EXTRA = 8'hf7;

    // reset values
    localparam logic [7:0] RST_REG = 8'h00;

    // register values with a meaning
    localparam logic [7:0] DSP_MODE_TX_TEST = 8'h05;
    localparam logic [7:0] MOD_QAM_2400 = 8'h06;
    localparam logic [7:0] MOD_PSK_1200_A = 8'h02;
    localparam logic [7:0] MOD_PSK_1200_B = 8'h00;
    localparam logic [7:0] MOD_FSK_300 = 8'h01;
    localparam logic [7:0] PATTERN_ZEROS = 8'h00;
    localparam logic [7:0] PATTERN_ONES = 8'hff;
    localparam logic [7:0] CID_JAPAN = 8'h80;
    localparam logic [7:0] COUNTRY_EUROPE = 8'h1c;
    localparam logic [7:0] COUNTRY_AUSTRALIA = 8'h38;
    localparam logic [7:0] COUNTRY_KOREA = 8'h06;
    localparam logic [7:0] EXTRA_EUROPE = 8'h18;

    // field positions
    localparam int TX_ON_BIT = 0;
    localparam int MOD_KIND_BIT = 2;
    localparam int DIRECTION_BIT = 3;
    localparam int GUARD_550_BIT = 4;
    localparam int GUARD_1800_BIT = 5;
    localparam int ALERT_HI_BIT = 7;
    localparam int ALERT_LO_BIT = 6;

    // command characters
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_D = 8'h44;
    localparam logic [7:0] CH_EQ = 8'h3d;
    localparam logic [7:0] CH_CR = 8'h0d;

    // progress events, index into the result table
    localparam int EV_NUM = 9;
    localparam int EV_DIAL_TONE = 0;
    localparam int EV_DIAL_DONE = 1;
    localparam int EV_RINGBACK = 2;
    localparam int EV_BUSY = 3;
    localparam int EV_NO_CARRIER = 4;
    localparam int EV_CONNECT = 5;
    localparam int EV_CONNECT_1200 = 6;
    localparam int EV_CID_REVERSAL = 7;
    localparam int EV_CID_MARK = 8;

    // result characters in event order
    localparam logic [EV_NUM*8-1:0] RESULT_CHARS =
        {8'h6d, 8'h66, 8'h64, 8'h63, 8'h4e, 8'h62, 8'h72, 8'h2c, 8'h74};

    typedef enum logic [1:0] {
        MCS_DATA_QAM_2400 = 2'h0,
        MCS_DATA_PSK_1200 = 2'h1,
        MCS_DATA_FSK_300 = 2'h2,
        MCS_DATA_NONE = 2'h3
    } mcs_data_mode_t;

    // ascii hex digit to nibble, valid flag in bit 4
    function automatic logic [4:0] mcs_hex(input logic [7:0] c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 8'h30 && c <= 8'h39)
        begin
            r = {1'b1, 4'(c - 8'h30)};
        end
        else if (c >= 8'h41 && c <= 8'h46)
        begin
            r = {1'b1, 4'(c - 8'h37)};
        end
        else if (c >= 8'h61 && c <= 8'h66)
        begin
            r = {1'b1, 4'(c - 8'h57)};
        end
        return r;
    endfunction

endpackage

// ===== hdl/mcs_result_tx.sv
// result character and payload sender toward the host
`timescale 1ns/100ps
`default_nettype none
module mcs_result_tx
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [mcs_pkg::EV_NUM-1:0] i_event,
    input wire logic [7:0] i_data,
    input wire logic i_data_valid,
    output logic o_data_ready,
    output logic [7:0] o_byte,
    output logic o_valid,
    input wire logic i_ready
);
    import mcs_pkg::*;

    logic [EV_NUM-1:0] pend_q;
    logic [EV_NUM-1:0] pend_d;
    logic [EV_NUM-1:0] take;
    logic [EV_NUM-1:0] lower;
    logic [7:0] byte_q;
    logic valid_q;
    logic [7:0] pick_char;
    wire slot_free = !valid_q || i_ready;
    wire any_pend = |pend_q;
    wire load_data = slot_free && !any_pend && i_data_valid;

    // ----------------------------------------------------------------
    // pending events, lowest index first, new event wins over take
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < EV_NUM; g++)
        begin : g_ev
            if (g == 0)
            begin : g_first
                assign lower[g] = 1'b0;
            end
            else
            begin : g_rest
                assign lower[g] = lower[g-1] | pend_q[g-1];
            end
            assign take[g] = slot_free && pend_q[g] && !lower[g];
            assign pend_d[g] = (pend_q[g] && !take[g]) || i_event[g];
        end
    endgenerate

    always_comb
    begin
        pick_char = 8'h00;
        for (int i = 0; i < EV_NUM; i++)
        begin
            if (take[i])
            begin
                pick_char = RESULT_CHARS[i*8 +: 8];
            end
        end
    end

    // ----------------------------------------------------------------
    // output holding register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            pend_q <= '0;
            byte_q <= 8'h00;
            valid_q <= 1'b0;
        end
        else if (i_ce)
        begin
            pend_q <= pend_d;
            if (slot_free)
            begin
                valid_q <= any_pend || i_data_valid;
                byte_q <= any_pend ? pick_char : i_data;
            end
        end
    end

    assign o_data_ready = load_data && i_ce;
    assign o_byte = byte_q;
    assign o_valid = valid_q;

endmodule
`default_nettype wire

// ===== hdl/mcs_modem_ctrl.sv
// modem command interpreter: register writes, dialing, test mode, data path
`timescale 1ns/100ps
`default_nettype none
module mcs_modem_ctrl
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_rx_byte,
    input wire logic i_rx_valid,
    output logic o_cts,
    output logic [7:0] o_host_byte,
    output logic o_host_valid,
    input wire logic i_host_ready,
    input wire logic i_ev_dial_tone,
    input wire logic i_ev_dial_done,
    input wire logic i_ev_ringback,
    input wire logic i_ev_busy,
    input wire logic i_ev_no_carrier,
    input wire logic i_ev_connect,
    input wire logic i_ev_connect_1200,
    input wire logic i_ev_cid_reversal,
    input wire logic i_ev_cid_mark,
    input wire logic i_line_event,
    input wire logic [7:0] i_line_rx_byte,
    input wire logic i_line_rx_valid,
    output logic o_line_rx_ready,
    output logic [7:0] o_line_tx_byte,
    output logic o_line_tx_valid,
    input wire logic i_line_tx_ready,
    output logic o_dial_start,
    output logic o_online,
    output mcs_pkg::mcs_data_mode_t o_data_mode,
    output logic o_test_mode,
    output logic o_tx_on,
    output logic o_mod_qam,
    output logic o_originate,
    output logic o_guard_550,
    output logic o_guard_1800,
    output logic o_pattern_zeros,
    output logic o_pattern_ones,
    output logic [7:0] o_line_if_country,
    output logic [7:0] o_line_if_extra,
    output logic o_cid_japan,
    output logic o_alert
);
    import mcs_pkg::*;

    typedef enum logic [9:0] {
        ST_IDLE = 10'b0000000001,
        ST_GOT_A = 10'b0000000010,
        ST_CMD = 10'b0000000100,
        ST_REG_HI = 10'b0000001000,
        ST_REG_LO = 10'b0000010000,
        ST_EQ = 10'b0000100000,
        ST_VAL_HI = 10'b0001000000,
        ST_VAL_LO = 10'b0010000000,
        ST_DIAL = 10'b0100000000,
        ST_ONLINE = 10'b1000000000
    } mcs_state_t;

    mcs_state_t state_q;
    mcs_state_t state_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic [3:0] nib_q;
    logic [3:0] nib_d;
    logic [7:0] modsel_q;
    logic [7:0] cidfmt_q;
    logic [7:0] alert_en_q;
    logic [7:0] txctl_q;
    logic [7:0] pattern_q;
    logic [7:0] dspmode_q;
    logic [7:0] country_q;
    logic [7:0] extra_q;
    logic alert_q;
    logic [7:0] ltx_byte_q;
    logic ltx_valid_q;
    logic dial_q;
    logic wr_en;
    logic [7:0] wr_data;
    logic [EV_NUM-1:0] events;
    logic rsp_busy;

    // ----------------------------------------------------------------
    // host byte acceptance
    // ----------------------------------------------------------------
    wire in_online = (state_q == ST_ONLINE);
    wire ltx_free = !ltx_valid_q || i_line_tx_ready;
    assign o_cts = in_online ? ltx_free : !rsp_busy;
    wire rx_take = i_rx_valid && o_cts && i_ce;
    wire [4:0] hex = mcs_hex(i_rx_byte);
    wire is_cr = (i_rx_byte == CH_CR);
    wire connected = i_ev_connect || i_ev_connect_1200;

    // ----------------------------------------------------------------
    // command parser
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        addr_d = addr_q;
        nib_d = nib_q;
        wr_en = 1'b0;
        wr_data = {nib_q, hex[3:0]};
        unique case (state_q)
            ST_IDLE:
            begin
                if (rx_take && i_rx_byte == CH_A)
                begin
                    state_d = ST_GOT_A;
                end
            end
            ST_GOT_A:
            begin
                if (rx_take)
                begin
                    state_d = (i_rx_byte == CH_T) ? ST_CMD : ST_IDLE;
                end
            end
            ST_CMD:
            begin
                if (rx_take)
                begin
                    if (i_rx_byte == CH_S)
                    begin
                        state_d = ST_REG_HI;
                    end
                    else if (i_rx_byte == CH_D)
                    begin
                        state_d = ST_DIAL;
                    end
                    else if (is_cr)
                    begin
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_REG_HI, ST_REG_LO, ST_VAL_HI, ST_VAL_LO:
            begin
                if (rx_take)
                begin
                    if (!hex[4])
                    begin
                        state_d = is_cr ? ST_IDLE : ST_CMD;
                    end
                    else if (state_q == ST_REG_HI || state_q == ST_VAL_HI)
                    begin
                        nib_d = hex[3:0];
                        state_d = (state_q == ST_REG_HI) ? ST_REG_LO : ST_VAL_LO;
                    end
                    else if (state_q == ST_REG_LO)
                    begin
                        addr_d = wr_data;
                        state_d = ST_EQ;
                    end
                    else
                    begin
                        wr_en = 1'b1;
                        state_d = ST_CMD;
                    end
                end
            end
            ST_EQ:
            begin
                if (rx_take)
                begin
                    state_d = (i_rx_byte == CH_EQ) ? ST_VAL_HI : ST_CMD;
                end
            end
            ST_DIAL:
            begin
                if (connected)
                begin
                    state_d = ST_ONLINE;
                end
                else if (i_ev_no_carrier || i_ev_busy)
                begin
                    state_d = ST_IDLE;
                end
            end
            ST_ONLINE:
            begin
                if (i_ev_no_carrier)
                begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state, parser and register storage
    // ----------------------------------------------------------------
    wire dial_go = (state_q == ST_CMD) && rx_take && i_rx_byte == CH_D;
    wire wr_alert = wr_en && addr_q == REG_ALERT_ENABLE;
    wire alert_on = alert_en_q[ALERT_HI_BIT] && alert_en_q[ALERT_LO_BIT];

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_IDLE;
            addr_q <= RST_REG;
            nib_q <= 4'h0;
            dial_q <= 1'b0;
        end
        else if (i_ce)
        begin
            state_q <= state_d;
            addr_q <= addr_d;
            nib_q <= nib_d;
            dial_q <= dial_go;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            modsel_q <= RST_REG;
            cidfmt_q <= RST_REG;
            alert_en_q <= RST_REG;
            txctl_q <= RST_REG;
            pattern_q <= RST_REG;
            dspmode_q <= RST_REG;
            country_q <= RST_REG;
            extra_q <= RST_REG;
        end
        else if (i_ce && wr_en)
        begin
            unique case (addr_q)
                REG_MODULATION_SELECT: modsel_q <= wr_data;
                REG_CALLER_ID_FORMAT: cidfmt_q <= wr_data;
                REG_ALERT_ENABLE: alert_en_q <= wr_data;
                REG_TX_TEST_CONTROL: txctl_q <= wr_data;
                REG_TX_TEST_PATTERN: pattern_q <= wr_data;
                REG_DSP_MODE: dspmode_q <= wr_data;
                REG_LINE_IF_COUNTRY: country_q <= wr_data;
                REG_LINE_IF_EXTRA: extra_q <= wr_data;
                default: ;
            endcase
        end
    end

    // sticky alert, new line event wins over the clear write
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            alert_q <= 1'b0;
        end
        else if (i_ce)
        begin
            alert_q <= (alert_q && !wr_alert) || (alert_on && i_line_event);
        end
    end

    // ----------------------------------------------------------------
    // payload toward the line while online
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            ltx_byte_q <= 8'h00;
            ltx_valid_q <= 1'b0;
        end
        else if (i_ce && ltx_free)
        begin
            ltx_valid_q <= in_online && rx_take;
            ltx_byte_q <= i_rx_byte;
        end
    end

    // ----------------------------------------------------------------
    // progress and caller ID reporting
    // ----------------------------------------------------------------
    wire dialing = (state_q == ST_DIAL);
    wire cid_jp = (cidfmt_q == CID_JAPAN);
    assign events[EV_DIAL_TONE] = dialing && i_ev_dial_tone;
    assign events[EV_DIAL_DONE] = dialing && i_ev_dial_done;
    assign events[EV_RINGBACK] = dialing && i_ev_ringback;
    assign events[EV_BUSY] = dialing && i_ev_busy;
    assign events[EV_NO_CARRIER] = (dialing || in_online) && i_ev_no_carrier;
    assign events[EV_CONNECT] = dialing && i_ev_connect;
    assign events[EV_CONNECT_1200] = dialing && !i_ev_connect && i_ev_connect_1200;
    assign events[EV_CID_REVERSAL] = cid_jp && i_ev_cid_reversal;
    assign events[EV_CID_MARK] = cid_jp && i_ev_cid_mark;

    mcs_result_tx u_result
    (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_event(events),
        .i_data(i_line_rx_byte),
        .i_data_valid(i_line_rx_valid),
        .o_data_ready(o_line_rx_ready),
        .o_byte(o_host_byte),
        .o_valid(o_host_valid),
        .i_ready(i_host_ready)
    );

    assign rsp_busy = o_host_valid && !i_host_ready;

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    wire test_mode = (dspmode_q == DSP_MODE_TX_TEST);
    assign o_test_mode = test_mode;
    assign o_tx_on = test_mode && txctl_q[TX_ON_BIT];
    assign o_mod_qam = test_mode && txctl_q[MOD_KIND_BIT];
    assign o_originate = test_mode && txctl_q[DIRECTION_BIT];
    assign o_guard_550 = test_mode && txctl_q[GUARD_550_BIT];
    assign o_guard_1800 = test_mode && txctl_q[GUARD_1800_BIT];
    assign o_pattern_zeros = test_mode && pattern_q == PATTERN_ZEROS;
    assign o_pattern_ones = test_mode && pattern_q == PATTERN_ONES;

    wire sel_qam = (modsel_q == MOD_QAM_2400);
    wire sel_psk = (modsel_q == MOD_PSK_1200_A) || (modsel_q == MOD_PSK_1200_B);
    wire sel_fsk = (modsel_q == MOD_FSK_300);
    assign o_data_mode = sel_qam ? MCS_DATA_QAM_2400 :
        sel_psk ? MCS_DATA_PSK_1200 :
        sel_fsk ? MCS_DATA_FSK_300 : MCS_DATA_NONE;

    assign o_line_if_country = country_q;
    assign o_line_if_extra = extra_q;
    assign o_cid_japan = cid_jp;
    assign o_alert = alert_q;
    assign o_online = in_online;
    assign o_dial_start = dial_q;
    assign o_line_tx_byte = ltx_byte_q;
    assign o_line_tx_valid = ltx_valid_q;

endmodule
`default_nettype wire

// ===== testbench/mcs_modem_ctrl_properties.sv
// assertion checker for the modem command interpreter
`timescale 1ns/100ps
`default_nettype none
module mcs_ctrl_props
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_rx_valid,
    input wire logic o_cts,
    input wire logic [7:0] o_host_byte,
    input wire logic o_host_valid,
    input wire logic i_host_ready,
    input wire logic i_ev_connect,
    input wire logic i_ev_connect_1200,
    input wire logic i_line_event,
    input wire logic [7:0] o_line_tx_byte,
    input wire logic o_line_tx_valid,
    input wire logic i_line_tx_ready,
    input wire logic o_dial_start,
    input wire logic o_online,
    input wire mcs_pkg::mcs_data_mode_t o_data_mode,
    input wire logic o_test_mode,
    input wire logic o_tx_on,
    input wire logic o_mod_qam,
    input wire logic o_originate,
    input wire logic o_guard_550,
    input wire logic o_guard_1800,
    input wire logic o_pattern_zeros,
    input wire logic o_pattern_ones,
    input wire logic o_alert
);
    import mcs_pkg::*;
    wire logic taken = i_rx_valid && o_cts && i_ce;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    test_gate_a: assert property (!o_test_mode |-> !(o_tx_on || o_mod_qam || o_originate
        || o_guard_550 || o_guard_1800 || o_pattern_zeros || o_pattern_ones))
        else $error("test controls active outside test mode");
    test_entry_a: assert property ($rose(o_test_mode) |-> $past(taken))
        else $error("test mode entered without a host byte");
    pattern_excl_a: assert property (!(o_pattern_zeros && o_pattern_ones))
        else $error("both test patterns selected");
    mode_cause_a: assert property (!$stable(o_data_mode) |-> $past(taken))
        else $error("data mode changed without a host byte");
    dial_pulse_a: assert property (o_dial_start |=> !o_dial_start)
        else $error("dial start longer than one cycle");
    host_hold_a: assert property (o_host_valid && !i_host_ready |=>
        o_host_valid && $stable(o_host_byte)) else $error("host byte dropped while stalled");
    online_cause_a: assert property ($rose(o_online) |->
        $past(i_ev_connect || i_ev_connect_1200)) else $error("online without connect");
    line_hold_a: assert property (o_line_tx_valid && !i_line_tx_ready |=>
        o_line_tx_valid && $stable(o_line_tx_byte)) else $error("line byte dropped");
    cts_wait_a: assert property (o_host_valid && !i_host_ready && !o_online |-> !o_cts)
        else $error("clear to send while result pending");
    alert_rise_a: assert property ($rose(o_alert) |-> $past(i_line_event))
        else $error("alert raised without line event");
    alert_keep_a: assert property ($fell(o_alert) |-> $past(taken))
        else $error("alert cleared without a host write");
    reset_vals_a: assert property (disable iff (1'b0) !i_rst_b && i_ce |=>
        !o_test_mode && !o_alert && !o_online && o_data_mode == MCS_DATA_PSK_1200)
        else $error("reset values wrong");
    cover property ($rose(o_online));
    cover property ($rose(o_alert));
    cover property ($rose(o_test_mode));
endmodule
bind mcs_modem_ctrl mcs_ctrl_props chk_u (.*);
`default_nettype wire

// ===== testbench/mcs_host_model.sv
// host microcontroller model: command sender and result receiver
`timescale 1ns/100ps
`default_nettype none
module mcs_host_model
(
    input wire logic i_clk,
    input wire logic i_cts,
    input wire logic [7:0] i_host_byte,
    input wire logic i_host_valid,
    input wire logic i_stall,
    output logic [7:0] o_rx_byte,
    output logic o_rx_valid,
    output logic o_host_ready
);
    logic [7:0] got_q[$];
    initial
    begin
        o_rx_byte = 8'h00;
        o_rx_valid = 1'b0;
    end
    assign o_host_ready = !i_stall;
    always @(posedge i_clk)
    begin
        if (i_host_valid && o_host_ready)
            got_q.push_back(i_host_byte);
    end
    // one byte, held until clear-to-send takes it
    task automatic send(input logic [7:0] b);
        @(negedge i_clk);
        o_rx_byte = b;
        o_rx_valid = 1'b1;
        do @(posedge i_clk); while (!i_cts);
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_byte = ~b;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking testbench for the modem command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import mcs_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    logic [9:0] ev = '0;
    logic [31:0] rnd = 32'ha6e4;
    logic [7:0] i_rx_byte, o_host_byte, i_line_rx_byte, o_line_tx_byte;
    logic [7:0] o_line_if_country, o_line_if_extra, v;
    logic i_rx_valid, o_cts, o_host_valid, i_host_ready, i_line_rx_valid, o_line_rx_ready;
    logic o_line_tx_valid, i_line_tx_ready, o_dial_start, o_online, o_test_mode, o_tx_on;
    logic o_mod_qam, o_originate, o_guard_550, o_guard_1800, o_pattern_zeros;
    logic o_pattern_ones, o_cid_japan, o_alert;
    mcs_data_mode_t o_data_mode;
    logic [7:0] line_q[$];
    logic [7:0] tab[9] = '{8'h74, 8'h2c, 8'h72, 8'h62, 8'h4e, 8'h63, 8'h64, 8'h66, 8'h6d};
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_dial = 0;
    mcs_modem_ctrl dut_u (.i_clk, .i_rst_b, .i_ce, .i_rx_byte, .i_rx_valid, .o_cts,
        .o_host_byte, .o_host_valid, .i_host_ready, .i_ev_dial_tone(ev[0]),
        .i_ev_dial_done(ev[1]), .i_ev_ringback(ev[2]), .i_ev_busy(ev[3]),
        .i_ev_no_carrier(ev[4]), .i_ev_connect(ev[5]), .i_ev_connect_1200(ev[6]),
        .i_ev_cid_reversal(ev[7]), .i_ev_cid_mark(ev[8]), .i_line_event(ev[9]),
        .i_line_rx_byte, .i_line_rx_valid, .o_line_rx_ready, .o_line_tx_byte,
        .o_line_tx_valid, .i_line_tx_ready, .o_dial_start, .o_online, .o_data_mode,
        .o_test_mode, .o_tx_on, .o_mod_qam, .o_originate, .o_guard_550, .o_guard_1800,
        .o_pattern_zeros, .o_pattern_ones, .o_line_if_country, .o_line_if_extra,
        .o_cid_japan, .o_alert);
    mcs_host_model host_u (.i_clk, .i_cts(o_cts), .i_host_byte(o_host_byte),
        .i_host_valid(o_host_valid), .i_stall(rnd[1] & rnd[4]), .o_rx_byte(i_rx_byte),
        .o_rx_valid(i_rx_valid), .o_host_ready(i_host_ready));
    // ----------------------------------------
    // clock, random source, line side
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    always #10 i_clk = ~i_clk;
    always @(negedge i_clk) rnd <= lfsr(rnd);
    assign i_line_tx_ready = !(rnd[2] & rnd[6]);
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        n_dial <= n_dial + int'(o_dial_start);
        if (o_line_tx_valid && i_line_tx_ready)
            line_q.push_back(o_line_tx_byte);
        if (cyc == 20000)
        begin
            fails++;
            conclude();
        end
    end
    // ----------------------------------------
    // checking and stimulus tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chk({7'h00, g}, {7'h00, e});
    endtask
    function automatic mcs_data_mode_t exp_mode(input logic [7:0] m);
        case (m)
            8'h06: return MCS_DATA_QAM_2400;
            8'h02, 8'h00: return MCS_DATA_PSK_1200;
            8'h01: return MCS_DATA_FSK_300;
            default: return MCS_DATA_NONE;
        endcase
    endfunction
    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++)
            host_u.send(s[i]);
        @(negedge i_clk);
    endtask
    task automatic cmd(input logic [7:0] r, input logic [7:0] d);
        send_str($sformatf("ATS%02h=%02h\r", r, d));
    endtask
    task automatic pulse(input int k);
        @(negedge i_clk);
        ev[k] = 1'b1;
        @(negedge i_clk);
        ev = '0;
    endtask
    task automatic expect_chr(input logic [7:0] e);
        for (int n = 0; n < 100 && host_u.got_q.size() == 0; n++)
            @(negedge i_clk);
        chk(host_u.got_q.size() ? host_u.got_q.pop_front() : 8'hxx, e);
    endtask
    task automatic step(input int k);
        pulse(k);
        expect_chr(tab[k]);
    endtask
    task automatic line_in(input logic [7:0] b);
        @(negedge i_clk);
        i_line_rx_byte = b;
        i_line_rx_valid = 1'b1;
        do @(posedge i_clk); while (!o_line_rx_ready);
        @(negedge i_clk);
        i_line_rx_valid = 1'b0;
        i_line_rx_byte = ~b;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        i_line_rx_byte = 8'h00;
        i_line_rx_valid = 1'b0;
        repeat (8) @(negedge i_clk);
        i_rst_b = 1'b1;
        chkb(o_cts, 1'b1);
        chk(8'(o_data_mode), 8'(MCS_DATA_PSK_1200));
        cmd(REG_TX_TEST_CONTROL, 8'h3d);
        chkb(o_tx_on, 1'b0);
        cmd(REG_DSP_MODE, DSP_MODE_TX_TEST);
        chkb(o_test_mode, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
            cmd(REG_TX_TEST_CONTROL, v);
            chkb(o_tx_on, v[0]);
            chkb(o_mod_qam, v[2]);
            chkb(o_originate, v[3]);
            chk({6'h00, o_guard_1800, o_guard_550}, {6'h00, v[5:4]});
        end
        cmd(REG_TX_TEST_PATTERN, PATTERN_ZEROS);
        chkb(o_pattern_zeros, 1'b1);
        cmd(REG_TX_TEST_PATTERN, PATTERN_ONES);
        chk({6'h00, o_pattern_ones, o_pattern_zeros}, 8'h02);
        cmd(REG_DSP_MODE, 8'h00);
        chkb(o_tx_on, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            v = 8'(64'h06020001401c3806 >> (8 * (7 - i)));
            cmd((i < 5) ? REG_MODULATION_SELECT : REG_LINE_IF_COUNTRY, v);
            if (i < 5)
                chk(8'(o_data_mode), 8'(exp_mode(v)));
            else
                chk(o_line_if_country, v);
        end
        cmd(REG_LINE_IF_EXTRA, EXTRA_EUROPE);
        chk(o_line_if_extra, 8'h18);
        cmd(8'h99, 8'h12);
        chk(o_line_if_country, 8'h06);
        pulse(9);
        chkb(o_alert, 1'b0);
        cmd(REG_ALERT_ENABLE, 8'hc0);
        pulse(9);
        chkb(o_alert, 1'b1);
        repeat (20) @(negedge i_clk);
        chkb(o_alert, 1'b1);
        cmd(REG_ALERT_ENABLE, 8'hc0);
        chkb(o_alert, 1'b0);
        i_ce = 1'b0;
        pulse(9);
        chkb(o_alert, 1'b0);
        i_ce = 1'b1;
        cmd(REG_CALLER_ID_FORMAT, CID_JAPAN);
        chkb(o_cid_japan, 1'b1);
        step(7);
        step(8);
        line_in(8'h5a);
        expect_chr(8'h5a);
        send_str("ATDT5\r");
        for (int k = 0; k < 3; k++)
            step(k);
        step(5);
        chkb(o_online, 1'b1);
        for (int i = 0; i < 4; i++)
            host_u.send(8'h41 + 8'(i));
        repeat (20) @(negedge i_clk);
        for (int i = 0; i < 4; i++)
            chk(line_q.size() ? line_q.pop_front() : 8'hxx, 8'h41 + 8'(i));
        line_in(8'h3c);
        expect_chr(8'h3c);
        step(4);
        chkb(o_online, 1'b0);
        send_str("ATD7\r");
        step(3);
        send_str("ATD1\r");
        step(6);
        chkb(o_online, 1'b1);
        chk(8'(n_dial), 8'h03);
        conclude();
    end
endmodule
`default_nettype wire
